// ===== vtsb_pkg.sv
// Purpose: shared constants, types and register layout of the voltage target slew and blanking
//          core
// Assumes: pclk at 20 MHz; one code step is 12.5 mV; voltages are held in units of 0.1 mV
// Notes:   every pclk cycle count is derived here from its time in ns or us
package vtsb_pkg;

  // clock
  localparam int unsigned CLK_PERIOD_NS = 50;
  // one code step of 12.5 mV per us at the nominal rate setting
  localparam int unsigned NORM_STEP_NS  = 1000;
  localparam logic [15:0] RATE_DEFAULT  = 16'(NORM_STEP_NS / CLK_PERIOD_NS);
  // fast exit: at least 50 mV/us, so a step may take at most 250 ns (rounded down)
  localparam int unsigned FAST_STEP_NS  = 250;
  localparam int unsigned FAST_STEP_CYC = (FAST_STEP_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                          (FAST_STEP_NS / CLK_PERIOD_NS);
  // soft-start/stop run at 1/8 and slow exit at 1/4 of the programmed rate
  localparam int unsigned SOFT_DIV_SHIFT = 3;
  localparam int unsigned SLOW_DIV_SHIFT = 2;
  localparam int unsigned STEP_W         = 19;
  // blanking after a transition: at least 20 us (rounded up)
  localparam int unsigned BLANK_TIME_US = 20;
  localparam int unsigned BLANK_CYCLES  = (BLANK_TIME_US * 1000 + CLK_PERIOD_NS - 1) /
                                          CLK_PERIOD_NS;
  // phase-good held off for this many phase-2 switching cycles
  localparam logic [5:0]  PHASE_SETTLE_CYCLES = 6'h20;

  // code table: 1.5000 V at code 0, falling 12.5 mV per code, upper four bits all ones -> 0 V
  localparam int unsigned VID_W      = 7;
  localparam logic [15:0] V_TOP_0P1MV = 16'h3A98;
  localparam logic [15:0] V_LSB_0P1MV = 16'h007D;
  localparam logic [3:0]  ZERO_PREFIX = 4'hF;
  localparam logic [6:0]  CODE_OFF    = 7'h7F;

  // register byte offsets
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_RATE     = 8'h04;
  localparam logic [7:0] REG_STATUS   = 8'h08;
  localparam logic [7:0] REG_IRQ_STAT = 8'h0C;
  localparam logic [7:0] REG_IRQ_EN   = 8'h10;
  localparam logic [7:0] REG_IRQ_CLR  = 8'h14;
  localparam int unsigned IRQ_N       = 4;

  // operating modes
  typedef enum logic [2:0] {
    VTSB_OFF, VTSB_SOFT_START, VTSB_ACTIVE, VTSB_SLEEP, VTSB_FAST_EXIT, VTSB_SOFT_STOP
  } vtsb_mode_t;

  // analog comparator results, synchronous to pclk
  typedef struct packed {
    logic out_above_target;  // output still above the internal target
    logic out_below_low;     // output under the lower good threshold
    logic out_above_high;    // output over the upper good threshold
    logic phase_fault;       // phase current imbalance seen
  } vtsb_sense_t;

  // gate drive pair of one phase
  typedef struct packed {
    logic high;
    logic low;
  } vtsb_gate_t;

  // open-drain pin: o is the level driven while oe is high
  typedef struct packed {
    logic o;
    logic oe;
  } vtsb_od_t;

  // status register layout
  typedef struct packed {
    logic [17:0] unused;
    vtsb_mode_t  mode;
    logic        blank_over;
    logic        phase2_on;
    logic        skip;
    logic        slew_done;
    logic [6:0]  target_code;
  } vtsb_status_t;

  // interrupt bit layout
  typedef struct packed {
    logic pgood_fail;
    logic fast_exit;
    logic sleep_enter;
    logic slew_done;
  } vtsb_irq_t;

endpackage

// ===== vtsb_slew.sv
// Purpose: slewed target code register, one code step per rate tick toward the goal
// Assumes: step_cycles is at least one
// Notes:   a larger code is a lower voltage; direction only matters for the sign of the step
`timescale 1ns/1ps
module vtsb_slew
  import vtsb_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic [6:0]          goal_code,
  input  wire logic [STEP_W-1:0]   step_cycles,
  output logic      [6:0]          target_code,
  output logic                     done
);

  typedef struct packed {
    logic [6:0]        code;  // slewed target
    logic [STEP_W-1:0] cnt;   // cycles into the current step
  } vtsb_slew_st_t;

  vtsb_slew_st_t s_reg;
  vtsb_slew_st_t s_next;

  // next step: count the tick, then move one code toward the goal
  always_comb begin
    s_next = s_reg;
    if (s_reg.code == goal_code) begin
      s_next.cnt = '0;
    end else if (s_reg.cnt >= step_cycles - STEP_W'(1)) begin
      s_next.cnt  = '0;
      s_next.code = (goal_code > s_reg.code) ? s_reg.code + 7'h01 : s_reg.code - 7'h01;
    end else begin
      s_next.cnt = s_reg.cnt + STEP_W'(1);
    end
  end

  // register the state; the target starts at the zero-volt code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '{code: CODE_OFF, cnt: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign target_code = s_reg.code;
  assign done        = (s_reg.code == goal_code);

endmodule // vtsb_slew

// ===== vtsb_blank.sv
// Purpose: post-transition blanking timer
// Assumes: restart is a one-cycle pulse at each new transition
// Notes:   counts only while run is high, so it starts when the target arrives
`timescale 1ns/1ps
module vtsb_blank
  import vtsb_pkg::*;
#(
  parameter int unsigned CYCLES = BLANK_CYCLES
)(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic restart,
  input  wire logic run,
  output logic      expired
);

  typedef struct packed {
    logic [15:0] cnt;      // cycles since the target arrived
    logic        expired;  // interval over
  } vtsb_blank_st_t;

  vtsb_blank_st_t s_reg;
  vtsb_blank_st_t s_next;

  always_comb begin
    s_next = s_reg;
    if (restart) begin
      s_next = '{cnt: '0, expired: 1'b0};
    end else if (run && !s_reg.expired) begin
      s_next.cnt = s_reg.cnt + 16'h0001;
      if (s_reg.cnt == 16'(CYCLES - 1)) begin
        s_next.expired = 1'b1;
      end
    end
  end

  // state register; after reset everything counts as blanked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '{cnt: '0, expired: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign expired = s_reg.expired;

endmodule // vtsb_blank

// ===== vtsb_core.sv
// Purpose: target voltage sequencing, slew control and output blanking of a dual-phase
//          step-down controller
// Assumes: all pin and comparator inputs are synchronous to pclk; APB slave, no wait states
// Notes:   open-drain pins come out as level plus enable; the board resolves the wire
`timescale 1ns/1ps
module vtsb_core
  import vtsb_pkg::*;
#(
  parameter int unsigned BLANK_CYC = BLANK_CYCLES
)(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // processor pins
  input  wire logic [6:0]           voltage_id_bits,
  input  wire logic                 deep_sleep_request,
  input  wire logic                 slow_exit_request,
  input  wire logic                 power_state_select_n,
  // comparators and phase-2 modulator
  input  wire vtsb_pkg::vtsb_sense_t sense,
  input  wire vtsb_pkg::vtsb_gate_t  phase2_pwm,
  // phase-2 gate drive
  output logic                      phase2_high_gate,
  output logic                      phase2_low_gate,
  // regulation status
  output logic                      skip_mode,
  output logic      [6:0]           target_code,
  output logic      [15:0]          target_level,
  // open-drain outputs and interrupt
  output vtsb_pkg::vtsb_od_t        power_good_out,
  output vtsb_pkg::vtsb_od_t        clock_enable_out_n,
  output vtsb_pkg::vtsb_od_t        phase_ok_out,
  output logic                      irq
);

  import vtsb_pkg::*;

  // whole module state
  typedef struct packed {
    vtsb_mode_t  mode;        // operating mode
    logic        enable;      // software on/off
    logic [15:0] rate;        // cycles per code step at normal rate
    vtsb_irq_t   irq_stat;    // sticky events
    vtsb_irq_t   irq_en;      // event enables
    logic [31:0] rdata;       // read data captured in setup
    logic        dsr_prev;    // sleep request one cycle ago
    logic        psi_prev;    // power state input one cycle ago
    logic        pwm_prev;    // phase-2 high gate one cycle ago
    logic [5:0]  psettle;     // phase-2 cycles left before phase-good may report
    logic [6:0]  goal_prev;   // goal of the previous cycle
    logic        done_prev;   // slew completion one cycle ago
    logic        fail_prev;   // power-good failure one cycle ago
    logic        hg;          // registered phase-2 gates
    logic        lg;
    logic [15:0] level;       // registered target voltage
    vtsb_od_t    pg;          // registered open-drain outputs
    vtsb_od_t    ck;
    vtsb_od_t    po;
  } vtsb_core_st_t;

  vtsb_core_st_t s_reg;
  vtsb_core_st_t s_next;

  logic [6:0]        goal;         // code the slewer heads for
  logic [STEP_W-1:0] step_cyc;     // active cycles per step
  logic [6:0]        tcode;        // slewed target
  logic              slew_done;    // target at goal
  logic              blank_over;   // 20 us after arrival elapsed
  logic              restart;      // new transition begins
  logic              skip;         // pulse-skipping active
  logic              p2_on;        // phase 2 allowed to switch
  logic              dsr_rise;     // sleep request edges
  logic              dsr_fall;
  logic              lower_en;     // lower threshold checked
  logic              upper_en;     // upper threshold checked
  logic              fail;         // power-good check fails
  logic              po_blank;     // phase-good blanked
  logic              access;       // APB access phase
  logic              mapped;       // address decodes
  vtsb_irq_t         ev;           // events this cycle
  vtsb_irq_t         clr;          // clear strobe bits
  vtsb_status_t      status;       // status word

  function automatic logic [15:0] code_level(input logic [6:0] c);
    logic [15:0] v;
    v = V_TOP_0P1MV - 16'(c * V_LSB_0P1MV);
    if (c[6:3] == ZERO_PREFIX) begin
      v = '0;
    end
    return v;
  endfunction

  // goal and step rate per mode
  always_comb begin
    goal     = voltage_id_bits;
    step_cyc = STEP_W'(s_reg.rate);
    case (s_reg.mode)
      VTSB_OFF: begin
        goal = CODE_OFF;
      end
      VTSB_SOFT_START: begin
        step_cyc = STEP_W'(s_reg.rate) << SOFT_DIV_SHIFT;
      end
      VTSB_SOFT_STOP: begin
        goal     = CODE_OFF;
        step_cyc = STEP_W'(s_reg.rate) << SOFT_DIV_SHIFT;
      end
      VTSB_SLEEP: begin
        if (slow_exit_request) begin
          step_cyc = STEP_W'(s_reg.rate) << SLOW_DIV_SHIFT;
        end
      end
      VTSB_FAST_EXIT: begin
        step_cyc = STEP_W'(FAST_STEP_CYC);
      end
      default: begin
        step_cyc = STEP_W'(s_reg.rate);
      end
    endcase
    if (step_cyc == '0) begin
      step_cyc = STEP_W'(1);
    end
  end

  vtsb_slew u_slew (
    .pclk        (pclk),
    .presetn     (presetn),
    .goal_code   (goal),
    .step_cycles (step_cyc),
    .target_code (tcode),
    .done        (slew_done)
  );

  // one blanking timer for all transitions
  vtsb_blank #(
    .CYCLES (BLANK_CYC)
  ) u_blank (
    .pclk    (pclk),
    .presetn (presetn),
    .restart (restart),
    .run     (slew_done && s_reg.mode != VTSB_FAST_EXIT),
    .expired (blank_over)
  );

  assign dsr_rise = deep_sleep_request && !s_reg.dsr_prev;
  assign dsr_fall = !deep_sleep_request && s_reg.dsr_prev;
  assign access   = psel && penable;

  // address decode
  always_comb begin
    if (paddr == REG_CTRL) begin
      mapped = 1'b1;
    end else if (paddr == REG_RATE) begin
      mapped = 1'b1;
    end else if (paddr == REG_STATUS) begin
      mapped = 1'b1;
    end else if (paddr == REG_IRQ_STAT) begin
      mapped = 1'b1;
    end else if (paddr == REG_IRQ_EN) begin
      mapped = 1'b1;
    end else if (paddr == REG_IRQ_CLR) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  // mode derived controls; soft start and stop always force PWM on both phases
  always_comb begin
    skip  = (s_reg.mode == VTSB_SLEEP) || (s_reg.mode == VTSB_FAST_EXIT);
    p2_on = (s_reg.mode == VTSB_SOFT_START) || (s_reg.mode == VTSB_SOFT_STOP) ||
            ((s_reg.mode == VTSB_ACTIVE) && power_state_select_n);
    lower_en = blank_over;
    // upper check only in forced PWM
    upper_en = blank_over && !skip;
    fail     = (lower_en && sense.out_below_low) || (upper_en && sense.out_above_high);
    po_blank = !blank_over || deep_sleep_request || !p2_on || (s_reg.psettle != '0) ||
               (power_state_select_n && !s_reg.psi_prev);
  end

  // main next-state process
  always_comb begin
    s_next  = s_reg;
    restart = 1'b0;
    ev      = '0;
    clr     = '0;

    // mode sequencing
    case (s_reg.mode)
      VTSB_OFF: begin
        if (s_reg.enable) begin
          s_next.mode = VTSB_SOFT_START;
        end
      end
      VTSB_SOFT_START: begin
        if (!s_reg.enable) begin
          s_next.mode = VTSB_SOFT_STOP;
        end else if (slew_done) begin
          s_next.mode = deep_sleep_request ? VTSB_SLEEP : VTSB_ACTIVE;
        end
      end
      VTSB_ACTIVE: begin
        if (!s_reg.enable) begin
          s_next.mode = VTSB_SOFT_STOP;
        end else if (dsr_rise) begin
          s_next.mode    = VTSB_SLEEP;
          ev.sleep_enter = 1'b1;
        end
      end
      VTSB_SLEEP: begin
        if (!s_reg.enable) begin
          s_next.mode = VTSB_SOFT_STOP;
        end else if (dsr_fall) begin
          if (sense.out_above_target) begin
            s_next.mode  = VTSB_FAST_EXIT;
            ev.fast_exit = 1'b1;
          end else begin
            s_next.mode = VTSB_ACTIVE;
          end
        end
      end
      VTSB_FAST_EXIT: begin
        if (!s_reg.enable) begin
          s_next.mode = VTSB_SOFT_STOP;
        end else if (dsr_rise) begin
          s_next.mode    = VTSB_SLEEP;
          ev.sleep_enter = 1'b1;
        end else if (!sense.out_above_target) begin
          s_next.mode = VTSB_ACTIVE;
        end
      end
      VTSB_SOFT_STOP: begin
        if (s_reg.enable) begin
          s_next.mode = VTSB_SOFT_START;
        end else if (slew_done) begin
          s_next.mode = VTSB_OFF;
        end
      end
      default: begin
        s_next.mode = VTSB_OFF;
      end
    endcase

    if ((goal != s_reg.goal_prev) || (s_next.mode != s_reg.mode)) begin
      restart = 1'b1;
    end

    if (power_state_select_n && !s_reg.psi_prev) begin
      s_next.psettle = PHASE_SETTLE_CYCLES;
    end else if (phase2_pwm.high && !s_reg.pwm_prev && s_reg.psettle != '0) begin
      s_next.psettle = s_reg.psettle - 6'h01;
    end

    s_next.hg    = phase2_pwm.high && p2_on;
    s_next.lg    = phase2_pwm.low && p2_on;
    s_next.level = code_level(tcode);

    // open-drain pins; off pulls power-good and phase-good low, clock enable released
    if (s_reg.mode == VTSB_OFF) begin
      s_next.pg = '{o: 1'b0, oe: 1'b1};
      s_next.ck = '{o: 1'b0, oe: 1'b0};
      s_next.po = '{o: 1'b0, oe: 1'b1};
    end else begin
      s_next.pg = '{o: 1'b0, oe: blank_over && fail};
      s_next.ck = '{o: 1'b0, oe: blank_over && !fail};
      s_next.po = '{o: 1'b0, oe: !po_blank && sense.phase_fault};
    end

    // events
    ev.slew_done  = slew_done && !s_reg.done_prev;
    ev.pgood_fail = fail && !s_reg.fail_prev && (s_reg.mode != VTSB_OFF);

    // APB setup phase captures read data so it comes from a flop
    if (psel && !penable) begin
      s_next.rdata = '0;
      if (paddr == REG_CTRL) begin
        s_next.rdata = 32'(s_reg.enable);
      end else if (paddr == REG_RATE) begin
        s_next.rdata = 32'(s_reg.rate);
      end else if (paddr == REG_STATUS) begin
        s_next.rdata = status;
      end else if (paddr == REG_IRQ_STAT) begin
        s_next.rdata = 32'(s_reg.irq_stat);
      end else if (paddr == REG_IRQ_EN) begin
        s_next.rdata = 32'(s_reg.irq_en);
      end
    end

    // APB writes in the access phase; read-only words ignore writes
    if (access && pwrite) begin
      if (paddr == REG_CTRL) begin
        s_next.enable = pwdata[0];
      end else if (paddr == REG_RATE) begin
        s_next.rate = pwdata[15:0];
      end else if (paddr == REG_IRQ_EN) begin
        s_next.irq_en = vtsb_irq_t'(pwdata[IRQ_N-1:0]);
      end else if (paddr == REG_IRQ_CLR) begin
        clr = vtsb_irq_t'(pwdata[IRQ_N-1:0]);
      end
    end
    // a new event wins over a clear in the same cycle
    s_next.irq_stat = (s_reg.irq_stat & ~clr) | ev;

    s_next.dsr_prev  = deep_sleep_request;
    s_next.psi_prev  = power_state_select_n;
    s_next.pwm_prev  = phase2_pwm.high;
    s_next.goal_prev = goal;
    s_next.done_prev = slew_done;
    s_next.fail_prev = fail;
  end

  // status word
  always_comb begin
    status             = '0;
    status.target_code = tcode;
    status.slew_done   = slew_done;
    status.skip        = skip;
    status.phase2_on   = p2_on;
    status.blank_over  = blank_over;
    status.mode        = s_reg.mode;
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg           <= '0;
      s_reg.mode      <= VTSB_OFF;
      s_reg.rate      <= RATE_DEFAULT;
      s_reg.goal_prev <= CODE_OFF;
      s_reg.done_prev <= 1'b1;
      s_reg.psi_prev  <= 1'b1;
      s_reg.pg        <= '{o: 1'b0, oe: 1'b1};
      s_reg.po        <= '{o: 1'b0, oe: 1'b1};
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs
  assign prdata             = s_reg.rdata;
  assign pready             = 1'b1;
  assign pslverr            = access && !mapped;
  assign phase2_high_gate   = s_reg.hg;
  assign phase2_low_gate    = s_reg.lg;
  assign skip_mode          = skip;
  assign target_code        = tcode;
  assign target_level       = s_reg.level;
  assign power_good_out     = s_reg.pg;
  assign clock_enable_out_n = s_reg.ck;
  assign phase_ok_out       = s_reg.po;
  assign irq                = |(s_reg.irq_stat & s_reg.irq_en);

endmodule // vtsb_core

// ===== vtsb_host_model.sv
// Purpose: host processor model that drives the code and sleep pins
// Assumes: pins change only just after a rising pclk edge
// Notes:   the bench steers it through the drive task
`timescale 1ns/1ps
module vtsb_host_model (
  input  wire logic       pclk,
  output logic      [6:0] voltage_id_bits,
  output logic            deep_sleep_request,
  output logic            slow_exit_request,
  output logic            power_state_select_n
);
  // idle pins: full power, both phases wanted
  initial begin
    voltage_id_bits      = 7'h7F;
    deep_sleep_request   = 1'b0;
    slow_exit_request    = 1'b0;
    power_state_select_n = 1'b1;
  end
  // new levels land right after an edge, so no sample sees a half change
  task automatic drive(input logic [6:0] c, input logic s, input logic x, input logic p);
    @(posedge pclk);
    voltage_id_bits      <= c;
    deep_sleep_request   <= s;
    slow_exit_request    <= x;
    power_state_select_n <= p;
  endtask
endmodule // vtsb_host_model

// ===== vtsb_core_checker.sv
// Purpose: concurrent checks on the core pins
// Assumes: one pclk domain, presetn async active low
// Notes:   watches design outputs against their causes
`timescale 1ns/1ps
module vtsb_core_checker (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic [7:0]            paddr,
  input wire logic                  pslverr,
  input wire logic [6:0]            voltage_id_bits,
  input wire logic                  deep_sleep_request,
  input wire logic                  power_state_select_n,
  input wire vtsb_pkg::vtsb_sense_t sense,
  input wire logic                  phase2_high_gate,
  input wire logic                  phase2_low_gate,
  input wire logic                  skip_mode,
  input wire logic [6:0]            target_code,
  input wire vtsb_pkg::vtsb_od_t    power_good_out,
  input wire vtsb_pkg::vtsb_od_t    clock_enable_out_n,
  input wire vtsb_pkg::vtsb_od_t    phase_ok_out
);
  import vtsb_pkg::*;
  // all checks share the one clock and reset
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pok_sleep: assert property (deep_sleep_request |=> !phase_ok_out.oe)
    else $error("phase ok driven in sleep");
  a_gate_skip: assert property (skip_mode |=> !phase2_high_gate && !phase2_low_gate)
    else $error("phase 2 gate on while skipping");
  a_sleep_skip: assert property ($rose(deep_sleep_request) &&
    target_code == voltage_id_bits |-> ##[1:2] skip_mode)
    else $error("no skip after sleep request");
  a_code_step: assert property ($changed(target_code) |->
    target_code == 7'($past(target_code) + 7'h01) ||
    target_code == 7'($past(target_code) - 7'h01)) else $error("target jumped");
  a_blank_move: assert property (skip_mode && $changed(target_code) |=>
    !power_good_out.oe && !clock_enable_out_n.oe) else $error("outputs not blanked");
  a_upper_skip: assert property (skip_mode && $past(skip_mode) &&
    !$past(sense.out_below_low) |-> !power_good_out.oe) else $error("upper check in skip");
  a_fast_hold: assert property (skip_mode && !deep_sleep_request &&
    sense.out_above_target |=> skip_mode) else $error("skip left early");
  a_pok_psi: assert property ($rose(power_state_select_n) |=> (!phase_ok_out.oe) [*7])
    else $error("phase ok driven after phase 2 return");
  a_slverr_map: assert property (psel && penable && paddr > 8'h14 |-> pslverr)
    else $error("unmapped access not refused");
endmodule // vtsb_core_checker

bind vtsb_core vtsb_core_checker u_chk (.pclk, .presetn, .psel, .penable, .paddr, .pslverr,
  .voltage_id_bits, .deep_sleep_request, .power_state_select_n, .sense, .phase2_high_gate,
  .phase2_low_gate, .skip_mode, .target_code, .power_good_out, .clock_enable_out_n,
  .phase_ok_out);

// ===== testbench.sv
// Purpose: self-checking bench of the slew and blanking core
// Assumes: inputs change by NBA at rising edges, outputs are read at falling edges, APB read data and pslverr at a rising edge
// Notes:   blanking shortened to 20 cycles to keep the run brief
`timescale 1ns/1ps
`define CHK(nm, e, s) begin cmp_count++; if ((s) !== (e)) begin error_cnt++; \
  $display("BAD %s exp %0h got %0h", nm, e, s); end end
module testbench;
  import vtsb_pkg::*;
  localparam int BLK = 20;            // short blanking count
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, er, irq, skip_mode;
  logic [6:0]  voltage_id_bits, target_code, c;
  logic        deep_sleep_request, slow_exit_request, power_state_select_n;
  logic [15:0] target_level, seed = 16'h000D;  // seed of the random stream
  vtsb_sense_t sense = '0;
  vtsb_gate_t  phase2_pwm = '0;
  vtsb_od_t    power_good_out, clock_enable_out_n, phase_ok_out;
  logic [6:0]  tbl [3] = '{7'h20, 7'h77, 7'h78};  // table ends and first zero code
  int          error_cnt = 0, cmp_count = 0, g;

  always #25 pclk = ~pclk;
  vtsb_host_model u_host (.pclk, .voltage_id_bits, .deep_sleep_request, .slow_exit_request,
    .power_state_select_n);
  vtsb_core #(.BLANK_CYC(BLK)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .voltage_id_bits, .deep_sleep_request,
    .slow_exit_request, .power_state_select_n, .sense, .phase2_pwm, .phase2_high_gate(),
    .phase2_low_gate(), .skip_mode, .target_code, .target_level, .power_good_out,
    .clock_enable_out_n, .phase_ok_out, .irq);

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // 1.1 V at code 20h, 12.5 mV a step, top four bits set means 0 V
  function automatic logic [15:0] exp_lvl(input logic [6:0] k);
    if (k[6:3] == 4'hF) return 16'h0000;
    return 16'(11000 - (int'(k) - 32) * 125);
  endfunction
  // random modulator pattern keeps the phase-2 gate path busy
  always @(posedge pclk) begin
    seed       <= lfsr(seed);
    phase2_pwm <= seed[1:0];
  end
  // one apb transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (pready !== 1'b1) error_cnt++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic set_sense(input logic [3:0] v);
    @(posedge pclk);
    sense <= v;
  endtask
  // bounded wait for the target to reach a code; a timeout shows as a mismatch
  task automatic arrive(input logic [6:0] k);
    int n;
    n = 0;
    while (target_code !== k && n < 3000) begin
      @(negedge pclk);
      n++;
    end
    `CHK("arrive", k, target_code)
  endtask
  // cycles between two successive target steps
  task automatic step_gap(output int q);
    logic [6:0] t;
    int n;
    n = 0;
    q = 0;
    for (int i = 0; i < 2; i++) begin
      t = target_code;
      q = 0;
      while (target_code === t && n < 3000) begin
        @(negedge pclk);
        n++;
        q++;
      end
    end
  endtask
  task automatic give_verdict();
    if (error_cnt == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // watchdog, far beyond the expected run
  initial begin
    #1000000;
    error_cnt++;
    give_verdict();
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, REG_STATUS, 0);
    `CHK("st_code", 7'h7F, rd[6:0])
    `CHK("st_mode", 3'h0, rd[13:11])
    apb(0, 8'h20, 0);
    `CHK("slverr", 1'b1, er)
    `CHK("bad_rd", 32'h0, rd)
    apb(1, REG_RATE, 32'h6);
    u_host.drive(7'h70, 0, 0, 1);
    apb(1, REG_CTRL, 32'h1);
    step_gap(g);
    `CHK("soft_gap", 48, g)
    arrive(7'h70);
    apb(1, REG_IRQ_EN, 32'h1);
    // table corners then random codes inside the linear range
    for (int i = 0; i < 6; i++) begin
      c = (i < 3) ? tbl[i] : 7'(7'h20 + seed % 88);
      u_host.drive(c, 0, 0, 1);
      if (i == 0) begin
        step_gap(g);
        `CHK("gap", 6, g)
      end
      arrive(c);
      @(negedge pclk);
      `CHK("level", exp_lvl(c), target_level)
    end
    `CHK("irq", 1'b1, irq)
    apb(1, REG_IRQ_CLR, 32'h1);
    @(negedge pclk);
    `CHK("irq_clr", 1'b0, irq)
    apb(1, REG_IRQ_EN, 32'h0);
    u_host.drive(7'h50, 0, 0, 1);
    arrive(7'h50);
    // sleep entry with a low output that the blanking must hide
    u_host.drive(7'h50, 1, 0, 1);
    set_sense(4'b0100);
    u_host.drive(7'h60, 1, 0, 1);
    step_gap(g);
    `CHK("sleep_gap", 6, g)
    `CHK("skip", 1'b1, skip_mode)
    `CHK("pg_blank", 1'b0, power_good_out.oe)
    arrive(7'h60);
    repeat (3) @(negedge pclk);
    `CHK("pg_hold", 1'b0, power_good_out.oe)
    repeat (BLK + 3) @(negedge pclk);
    `CHK("pg_low", 1'b1, power_good_out.oe)
    set_sense(4'b0011);
    repeat (3) @(negedge pclk);
    `CHK("pg_up", 1'b0, power_good_out.oe)
    `CHK("ce_on", 1'b1, clock_enable_out_n.oe)
    `CHK("pok", 1'b0, phase_ok_out.oe)
    u_host.drive(7'h58, 1, 1, 1);
    step_gap(g);
    `CHK("slow_gap", 24, g)
    `CHK("slow_skip", 1'b1, skip_mode)
    // fast exit while the output is still above the new target
    set_sense(4'b1101);
    u_host.drive(7'h40, 0, 0, 1);
    step_gap(g);
    `CHK("fast_gap", 5, g)
    `CHK("fast_skip", 1'b1, skip_mode)
    `CHK("fast_pok", 1'b0, phase_ok_out.oe)
    set_sense(4'b0100);
    arrive(7'h40);
    repeat (3) @(negedge pclk);
    `CHK("exit_pg", 1'b0, power_good_out.oe)
    `CHK("exit_ce", 1'b0, clock_enable_out_n.oe)
    repeat (BLK + 3) @(negedge pclk);
    `CHK("pwm_low", 1'b1, power_good_out.oe)
    set_sense(4'b0011);
    repeat (3) @(negedge pclk);
    `CHK("pwm_up", 1'b1, power_good_out.oe)
    `CHK("pok_on", 1'b1, phase_ok_out.oe)
    u_host.drive(7'h40, 0, 0, 0);
    u_host.drive(7'h40, 0, 0, 1);
    repeat (4) @(negedge pclk);
    `CHK("psi_pok", 1'b0, phase_ok_out.oe)
    apb(1, REG_CTRL, 32'h0);
    step_gap(g);
    `CHK("stop_gap", 48, g)
    give_verdict();
  end
endmodule // testbench
